// ---- design/pll_base_clock_selector.sv ----
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R01] multiplier zero acts as multiplier one
// [R02] range zero disables pll and blocks vco selection
// [R03] switch waits three crystal and three vco cycles
// [R04] base clock output static during transition
// [R05] selected source divided by two, fifty percent duty
// [R06] select set picks vco, clear picks crystal
// [R07] vco never selected while pll on is clear
// [R08] pll cannot turn off while vco selected
// [R09] one write cannot change pll on and select together
// [R10] range zero forces crystal source
// [R11] run-in-stop keeps oscillator on, else follow system enable
// [R12] system integration drives the oscillator enable
// [R13] interrupt output comes from lock detector logic
// [R14] manual mode forces irq enable zero, writes ignored
// [R15] manual mode reads flag and lock as zero
// [R16] pll off or range zero forces select zero
// [R17] pll on blocks writes to programming registers
// [R18] select set forces pll on, writes ignored
// [R19] enable plus flag raises interrupt request
// [R20] reset clears irq enable
// [R21] lock toggle sets flag; control read or reset clears
// [R22] auto bit picks auto bandwidth, reset manual
// [R23] auto mode makes acquisition bit read-only status
// [R24] effective select gated by pll on and nonzero range
module pll_base_clock_selector (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic sys_osc_enable,
  input wire logic pll_lock_in,
  input wire logic pll_track_in,
  output logic base_clock_out,
  output logic osc_enable_out,
  output logic pll_enable_out,
  output logic [11:0] pll_multiplier_out,
  output logic [7:0] vco_range_value_out,
  output logic [1:0] vco_power_out,
  output logic acq_track_out,
  output logic clockgen_irq
);
  logic pll_irq_enable_reg;
  logic pll_irq_flag_reg;
  logic pll_on_a_reg;
  logic base_clock_select_reg;
  logic [1:0] vpr_reg;
  logic auto_reg;
  logic acquisition_mode_n_reg;
  logic [3:0] mul_hi_reg;
  logic [7:0] mul_lo_reg;
  logic [7:0] vco_range_value_reg;
  logic osc_run_in_stop_reg;
  logic lock_last_reg;
  logic active_src_reg;
  logic base_clock_reg;
  clockgen_pkg::sw_state_t sw_state_reg;
  clockgen_pkg::sw_state_t sw_state_next;
  logic wr;
  logic rd;
  logic range_zero;
  logic eff_select;
  logic lock_vis;
  logic acq_vis;
  logic xtal_tog;
  logic vco_tog;
  logic src_tog;
  logic [31:0] rdata_next;
  settle_if xtal_settle ();
  settle_if vco_settle ();

  // apb access phase, single cycle answer
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pslverr = 1'b0;
  assign range_zero = (vco_range_value_reg == clockgen_pkg::VRS_ZERO);

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_on_a_reg <= 1'b1;
      base_clock_select_reg <= 1'b0;
      vpr_reg <= clockgen_pkg::VPR_RST;
    end else begin
      if (range_zero || !pll_on_a_reg) begin
        base_clock_select_reg <= 1'b0; // [R16]
      end else if (wr && paddr == clockgen_pkg::PLL_CONTROL_ADDR) begin
        // select change only when pll on unchanged
        if (pwdata[clockgen_pkg::ON_BIT] == pll_on_a_reg) begin
          base_clock_select_reg <= pwdata[clockgen_pkg::BCS_BIT]; // [R06] [R09]
        end
      end
      if (wr && paddr == clockgen_pkg::PLL_CONTROL_ADDR) begin
        if (!base_clock_select_reg &&
            pwdata[clockgen_pkg::BCS_BIT] == base_clock_select_reg) begin
          pll_on_a_reg <= pwdata[clockgen_pkg::ON_BIT]; // [R08] [R09] [R18]
        end
        if (!pll_on_a_reg) begin
          vpr_reg <= pwdata[clockgen_pkg::VPR_LO +: 2]; // [R17]
        end
      end
    end
  end

  // irq enable and bandwidth mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_irq_enable_reg <= 1'b0; // [R20]
      auto_reg <= 1'b0; // [R22]
      acquisition_mode_n_reg <= 1'b0;
    end else begin
      if (wr && paddr == clockgen_pkg::PBWC_ADDR) begin
        auto_reg <= pwdata[clockgen_pkg::AUTO_BIT]; // [R22]
        if (!auto_reg) begin
          acquisition_mode_n_reg <= pwdata[clockgen_pkg::ACQ_BIT]; // [R23]
        end
      end
      if (!auto_reg) begin
        pll_irq_enable_reg <= 1'b0; // [R14]
      end else if (wr && paddr == clockgen_pkg::PLL_CONTROL_ADDR) begin
        pll_irq_enable_reg <= pwdata[clockgen_pkg::IE_BIT];
      end
    end
  end

  // lock toggle flag, set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_last_reg <= 1'b0;
      pll_irq_flag_reg <= 1'b0;
    end else begin
      lock_last_reg <= lock_vis;
      if (lock_vis != lock_last_reg) begin
        pll_irq_flag_reg <= 1'b1; // [R21]
      end else if (rd && paddr == clockgen_pkg::PLL_CONTROL_ADDR) begin
        pll_irq_flag_reg <= 1'b0; // [R21]
      end
    end
  end

  // programming registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mul_hi_reg <= clockgen_pkg::MUL_HI_RST;
      mul_lo_reg <= clockgen_pkg::MUL_LO_RST;
      vco_range_value_reg <= clockgen_pkg::VRS_RST;
    end else if (wr && !pll_on_a_reg) begin // [R17]
      if (paddr == clockgen_pkg::PMSH_ADDR) begin
        mul_hi_reg <= pwdata[3:0];
      end
      if (paddr == clockgen_pkg::PMSL_ADDR) begin
        mul_lo_reg <= pwdata[7:0];
      end
      if (paddr == clockgen_pkg::PMRS_ADDR) begin
        vco_range_value_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_in_stop_reg <= 1'b0;
    end else if (wr && paddr == clockgen_pkg::CFG2_ADDR) begin
      osc_run_in_stop_reg <= pwdata[clockgen_pkg::RIS_BIT];
    end
  end

  // status gating in manual mode
  assign lock_vis = auto_reg & pll_lock_in; // [R15]
  assign acq_vis = auto_reg ? pll_track_in : acquisition_mode_n_reg; // [R23]

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      clockgen_pkg::PLL_CONTROL_ADDR: begin
        rdata_next[clockgen_pkg::IE_BIT] = pll_irq_enable_reg;
        rdata_next[clockgen_pkg::IF_BIT] = pll_irq_flag_reg & auto_reg; // [R15]
        rdata_next[clockgen_pkg::ON_BIT] = pll_on_a_reg;
        rdata_next[clockgen_pkg::BCS_BIT] = base_clock_select_reg;
        rdata_next[clockgen_pkg::VPR_LO +: 2] = vpr_reg;
      end
      clockgen_pkg::PBWC_ADDR: begin
        rdata_next[clockgen_pkg::AUTO_BIT] = auto_reg;
        rdata_next[clockgen_pkg::LOCK_BIT] = lock_vis;
        rdata_next[clockgen_pkg::ACQ_BIT] = acq_vis;
      end
      clockgen_pkg::PMSH_ADDR: rdata_next[3:0] = mul_hi_reg;
      clockgen_pkg::PMSL_ADDR: rdata_next[7:0] = mul_lo_reg;
      clockgen_pkg::PMRS_ADDR: rdata_next[7:0] = vco_range_value_reg;
      clockgen_pkg::CFG2_ADDR: rdata_next[clockgen_pkg::RIS_BIT] = osc_run_in_stop_reg;
      clockgen_pkg::STAT_ADDR: begin
        rdata_next[clockgen_pkg::SRC_BIT] = active_src_reg;
        rdata_next[clockgen_pkg::BUSY_BIT] = (sw_state_reg != clockgen_pkg::SW_RUN);
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end
  assign prdata = rdata_next;

  // pll outputs
  assign pll_multiplier_out = ({mul_hi_reg, mul_lo_reg} == clockgen_pkg::MUL_ZERO) ?
    clockgen_pkg::MUL_ONE : {mul_hi_reg, mul_lo_reg}; // [R01]
  assign pll_enable_out = pll_on_a_reg & ~range_zero & sys_osc_enable; // [R02] [R12]
  assign osc_enable_out = osc_run_in_stop_reg | sys_osc_enable; // [R11]
  assign vco_range_value_out = vco_range_value_reg;
  assign vco_power_out = vpr_reg;
  assign acq_track_out = acq_vis;
  assign clockgen_irq = pll_irq_enable_reg & pll_irq_flag_reg & auto_reg; // [R13] [R19]

  // effective select after interlocks
  assign eff_select = base_clock_select_reg & pll_on_a_reg & ~range_zero; // [R07] [R10] [R24]

  // glitch-free transition
  always_comb begin
    sw_state_next = sw_state_reg;
    case (sw_state_reg)
      clockgen_pkg::SW_RUN: begin
        if (eff_select != active_src_reg) begin
          sw_state_next = clockgen_pkg::SW_STOP_OLD;
        end
      end
      clockgen_pkg::SW_STOP_OLD: begin
        if (active_src_reg ? vco_settle.done : xtal_settle.done) begin // [R03]
          sw_state_next = clockgen_pkg::SW_WAIT_NEW;
        end
      end
      clockgen_pkg::SW_WAIT_NEW: begin
        if (active_src_reg ? xtal_settle.done : vco_settle.done) begin // [R03]
          sw_state_next = clockgen_pkg::SW_DONE;
        end
      end
      clockgen_pkg::SW_DONE: sw_state_next = clockgen_pkg::SW_RUN;
      default: sw_state_next = clockgen_pkg::SW_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state_reg <= clockgen_pkg::SW_RUN;
      active_src_reg <= 1'b0;
    end else begin
      sw_state_reg <= sw_state_next;
      if (sw_state_reg == clockgen_pkg::SW_DONE) begin
        active_src_reg <= ~active_src_reg;
      end
    end
  end

  assign xtal_settle.start = (sw_state_reg == clockgen_pkg::SW_STOP_OLD && !active_src_reg) ||
    (sw_state_reg == clockgen_pkg::SW_WAIT_NEW && active_src_reg);
  assign vco_settle.start = (sw_state_reg == clockgen_pkg::SW_STOP_OLD && active_src_reg) ||
    (sw_state_reg == clockgen_pkg::SW_WAIT_NEW && !active_src_reg);

  settle_counter u_xtal_settle (
    .pclk(pclk),
    .presetn(presetn),
    .src_clk(crystal_clock),
    .port(xtal_settle.cnt)
  );
  settle_counter u_vco_settle (
    .pclk(pclk),
    .presetn(presetn),
    .src_clk(vco_clock),
    .port(vco_settle.cnt)
  );

  clock_select_core u_xtal_gate (
    .pclk(pclk),
    .presetn(presetn),
    .src_clk(crystal_clock),
    .enable(sw_state_reg == clockgen_pkg::SW_RUN && !active_src_reg),
    .toggle(xtal_tog)
  );
  clock_select_core u_vco_gate (
    .pclk(pclk),
    .presetn(presetn),
    .src_clk(vco_clock),
    .enable(sw_state_reg == clockgen_pkg::SW_RUN && active_src_reg),
    .toggle(vco_tog)
  );
  assign src_tog = xtal_tog | vco_tog; // [R04]

  // divide by two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_clock_reg <= 1'b0;
    end else if (src_tog) begin
      base_clock_reg <= ~base_clock_reg; // [R05]
    end
  end
  assign base_clock_out = base_clock_reg;
endmodule : pll_base_clock_selector
`default_nettype wire

// ---- design/clockgen_pkg.sv ----
package clockgen_pkg;
  // register byte addresses
  localparam logic [11:0] PLL_CONTROL_ADDR = 12'h000;
  localparam logic [11:0] PBWC_ADDR = 12'h004;
  localparam logic [11:0] PMSH_ADDR = 12'h008;
  localparam logic [11:0] PMSL_ADDR = 12'h00c;
  localparam logic [11:0] PMRS_ADDR = 12'h010;
  localparam logic [11:0] CFG2_ADDR = 12'h014;
  localparam logic [11:0] STAT_ADDR = 12'h018;
  // pll_control_reg fields
  localparam int IE_BIT = 7;
  localparam int IF_BIT = 6;
  localparam int ON_BIT = 5;
  localparam int BCS_BIT = 4;
  localparam int VPR_LO = 0;
  // bandwidth register fields
  localparam int AUTO_BIT = 7;
  localparam int LOCK_BIT = 6;
  localparam int ACQ_BIT = 5;
  // config_word_two / status fields
  localparam int RIS_BIT = 0;
  localparam int SRC_BIT = 0;
  localparam int BUSY_BIT = 1;
  // reset values, then zero and one compare constants
  localparam logic [3:0] MUL_HI_RST = 4'h0;
  localparam logic [7:0] MUL_LO_RST = 8'h40;
  localparam logic [7:0] VRS_RST = 8'h40;
  localparam logic [1:0] VPR_RST = 2'h0;
  localparam logic [11:0] MUL_ZERO = 12'h000;
  localparam logic [11:0] MUL_ONE = 12'h001;
  localparam logic [7:0] VRS_ZERO = 8'h00;
  // transition waits, source clock cycles
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  typedef enum logic [3:0] {
    SW_RUN = 4'b0001,
    SW_STOP_OLD = 4'b0010,
    SW_WAIT_NEW = 4'b0100,
    SW_DONE = 4'b1000
  } sw_state_t;
endpackage : clockgen_pkg

// ---- design/settle_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface settle_if;
  logic start;
  logic done;
  modport ctl (output start, input done);
  modport cnt (input start, output done);
endinterface : settle_if
`default_nettype wire

// ---- design/settle_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
// counts settle cycles of one source clock, sampled as a synchronous level
module settle_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_clk,
  settle_if.cnt port
);
  logic [1:0] cnt_reg;
  logic last_reg;
  logic rise;
  assign rise = src_clk & ~last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= src_clk;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
    end else if (!port.start) begin
      cnt_reg <= 2'h0;
    end else if (rise && cnt_reg != clockgen_pkg::SETTLE_CYCLES) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  assign port.done = port.start && (cnt_reg == clockgen_pkg::SETTLE_CYCLES);
endmodule : settle_counter
`default_nettype wire

// ---- design/clock_select_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// edge-gated clock slot for one source, cleared while held
module clock_select_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_clk,
  input wire logic enable,
  output logic toggle
);
  logic last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= src_clk;
    end
  end
  assign toggle = enable & src_clk & ~last_reg;
endmodule : clock_select_core
`default_nettype wire

// ---- verification/sys_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// system side: drives the oscillator enable, drops it in stop mode
module sys_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stop_req,
  output logic sys_osc_enable
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_osc_enable <= 1'b0;
    end else begin
      sys_osc_enable <= !stop_req;
    end
  end
endmodule : sys_partner
`default_nettype wire

// ---- verification/clockgen_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module clockgen_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pll_lock_in,
  input wire logic sys_osc_enable,
  input wire logic base_clock_out,
  input wire logic osc_enable_out,
  input wire logic pll_enable_out,
  input wire logic [11:0] pll_multiplier_out,
  input wire logic [7:0] vco_range_value_out,
  input wire logic clockgen_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_wr;
    psel && penable && pwrite;
  endsequence
  sequence ctl_rd;
    psel && penable && !pwrite && paddr == clockgen_pkg::PLL_CONTROL_ADDR;
  endsequence
  sequence lock_quiet;
    $stable(pll_lock_in) [*6];
  endsequence
  sequence prog_wr;
    acc_wr ##0 pll_enable_out && paddr inside {12'h008, 12'h00c, 12'h010};
  endsequence
  sequence cfg_on;
    acc_wr ##0 paddr == clockgen_pkg::CFG2_ADDR && pwdata[0];
  endsequence
  AST_MUL_NONZERO: assert property (
    pll_multiplier_out != 12'h000) else $error("multiplier output zero");
  AST_PLL_EN_RANGE: assert property (
    pll_enable_out |-> vco_range_value_out != 8'h00 && sys_osc_enable)
    else $error("pll enabled with zero range");
  AST_OSC_FOLLOW: assert property (
    sys_osc_enable |-> osc_enable_out) else $error("oscillator off while enabled");
  AST_STOP_RUN: assert property (
    cfg_on |=> osc_enable_out) else $error("run in stop ignored");
  AST_PROG_LOCKED: assert property (
    prog_wr |=> $stable(vco_range_value_out) && $stable(pll_multiplier_out))
    else $error("programming changed while pll on");
  AST_IRQ_CLEAR: assert property (
    lock_quiet ##0 ctl_rd |=> !clockgen_irq) else $error("irq kept after control read");
  AST_IRQ_HOLD: assert property (
    clockgen_irq && !penable |=> clockgen_irq) else $error("irq dropped without access");
  AST_BASE_RATE: assert property (
    $changed(base_clock_out) |=> $stable(base_clock_out)) else $error("base clock too fast");
endmodule : clockgen_checker
bind pll_base_clock_selector clockgen_checker chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pll_lock_in, .sys_osc_enable, .base_clock_out, .osc_enable_out,
  .pll_enable_out, .pll_multiplier_out, .vco_range_value_out, .clockgen_irq);
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, crystal_clock, vco_clock;
  logic sys_osc_enable, pll_lock_in, pll_track_in, stop_req, base_clock_out, osc_enable_out;
  logic pll_enable_out, acq_track_out, clockgen_irq;
  logic [11:0] paddr, pll_multiplier_out;
  logic [31:0] pwdata, prdata, r, rnd;
  logic [7:0] vco_range_value_out;
  logic [1:0] vco_power_out;
  int miscompares, checks_done, xc, vc, on, sel, ie, flg, vpr, mhi, mlo, rng, au, acquisition_mode_n, cfg, i;
  pll_base_clock_selector dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .crystal_clock, .vco_clock, .sys_osc_enable, .pll_lock_in,
    .pll_track_in, .base_clock_out, .osc_enable_out, .pll_enable_out, .pll_multiplier_out,
    .vco_range_value_out, .vco_power_out, .acq_track_out, .clockgen_irq);
  sys_partner far (.pclk, .presetn, .stop_req, .sys_osc_enable);
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // crystal period 6 cycles, vco period 4 cycles
  always @(posedge pclk) begin
    xc <= (xc + 1) % 6;
    vc <= (vc + 1) % 4;
    crystal_clock <= xc < 3;
    vco_clock <= vc < 2;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic fail_out;
    miscompares++;
    summarize;
  endtask : fail_out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_out;
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [31:0] mdl(input logic [11:0] a);
    case (a)
      clockgen_pkg::PLL_CONTROL_ADDR: return 32'(ie * 128 + (au & flg) * 64 + on * 32 + sel * 16 + vpr);
      clockgen_pkg::PBWC_ADDR: return 32'(au * 128 + (au & pll_lock_in) * 64
        + (au ? pll_track_in : acquisition_mode_n) * 32);
      clockgen_pkg::PMSH_ADDR: return 32'(mhi);
      clockgen_pkg::PMSL_ADDR: return 32'(mlo);
      clockgen_pkg::PMRS_ADDR: return 32'(rng);
      clockgen_pkg::CFG2_ADDR: return 32'(cfg);
      clockgen_pkg::STAT_ADDR: return 32'(sel);
      default: return 32'h0;
    endcase
  endfunction : mdl
  task automatic rd(input logic [11:0] a);
    apb(0, a, 0);
    chk("read", r, mdl(a));
    if (a == clockgen_pkg::PLL_CONTROL_ADDR) flg = 0;
  endtask : rd
  task automatic outs;
    chk("mult", pll_multiplier_out, (mhi * 256 + mlo) == 0 ? 1 : mhi * 256 + mlo);
    chk("range", vco_range_value_out, rng);
    chk("power", vco_power_out, vpr);
    chk("pll_en", pll_enable_out, on && rng != 0 && sys_osc_enable);
    chk("osc_en", osc_enable_out, cfg | sys_osc_enable);
    chk("irq", clockgen_irq, ie & flg & au);
  endtask : outs
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int o;
    apb(1, a, d);
    o = on;
    case (a)
      clockgen_pkg::PLL_CONTROL_ADDR: begin
        ie = au & d[7];
        if (!o) vpr = d[1:0];
        if (d[5] == o || d[4] == sel) begin
          if (!sel) on = d[5];
          sel = o && rng != 0 && d[4];
        end
      end
      clockgen_pkg::PBWC_ADDR: begin
        if (d[7] != au && pll_lock_in) flg = 1;
        if (!au) acquisition_mode_n = d[5];
        au = d[7];
        ie = ie & au;
      end
      clockgen_pkg::PMSH_ADDR: if (!o) mhi = d[3:0];
      clockgen_pkg::PMSL_ADDR: if (!o) mlo = d[7:0];
      clockgen_pkg::PMRS_ADDR: if (!o) rng = d[7:0];
      clockgen_pkg::CFG2_ADDR: cfg = d[0];
      default: ;
    endcase
    outs;
  endtask : wr
  task automatic tog;
    pll_lock_in <= ~pll_lock_in;
    repeat (8) @(posedge pclk);
    flg = flg | au;
  endtask : tog
  task automatic next_edge(output int c);
    logic b;
    b = base_clock_out;
    c = 0;
    while (base_clock_out === b && c < 300) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 300) fail_out;
  endtask : next_edge
  task automatic meas(input int p);
    int c;
    next_edge(c);
    next_edge(c);
    chk("half_period", c, p);
  endtask : meas
  task automatic sw(input logic [31:0] d, input int p);
    int c;
    wr(clockgen_pkg::PLL_CONTROL_ADDR, d);
    @(posedge pclk);
    next_edge(c);
    chk("frozen", c >= 10, 1);
    i = 0;
    do begin
      apb(0, clockgen_pkg::STAT_ADDR, 0);
      i++;
    end while (r[1:0] !== 2'(sel) && i < 30);
    if (i >= 30) fail_out;
    rd(clockgen_pkg::STAT_ADDR);
    meas(p);
  endtask : sw
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, stop_req, pll_lock_in} = '0;
    {pll_track_in, crystal_clock, vco_clock, xc, vc, miscompares, checks_done} = '0;
    {sel, ie, flg, vpr, mhi, au, acquisition_mode_n, cfg} = '0;
    rnd = 32'h3b1b15c1;
    on = 1;
    mlo = 'h40;
    rng = 'h40;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 8; i++) rd(12'(i * 4));
    wr(clockgen_pkg::PMRS_ADDR, 0);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 3);
    for (i = 2; i < 5; i++) begin
      rnd = xs(rnd);
      wr(12'(i * 4), rnd);
      rd(12'(i * 4));
    end
    wr(clockgen_pkg::PMSH_ADDR, 0);
    wr(clockgen_pkg::PMSL_ADDR, 0);
    wr(clockgen_pkg::PMRS_ADDR, 0);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 'h32);
    rd(clockgen_pkg::PLL_CONTROL_ADDR);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 'h22);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 'h32);
    rd(clockgen_pkg::PLL_CONTROL_ADDR);
    meas(6);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 0);
    wr(clockgen_pkg::PMRS_ADDR, 'h45);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 'h20);
    sw('h30, 4);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 0);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 'h10);
    rd(clockgen_pkg::PLL_CONTROL_ADDR);
    sw('h20, 6);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 'ha0);
    tog;
    rd(clockgen_pkg::PLL_CONTROL_ADDR);
    rd(clockgen_pkg::PBWC_ADDR);
    wr(clockgen_pkg::PBWC_ADDR, 'h80);
    wr(clockgen_pkg::PLL_CONTROL_ADDR, 'ha0);
    pll_track_in <= 1;
    tog;
    outs;
    rd(clockgen_pkg::PBWC_ADDR);
    rd(clockgen_pkg::PLL_CONTROL_ADDR);
    outs;
    stop_req <= 1;
    repeat (3) @(posedge pclk);
    outs;
    wr(clockgen_pkg::CFG2_ADDR, 1);
    stop_req <= 0;
    repeat (3) @(posedge pclk);
    outs;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
